// File: rtl/ucm_map.svh
// Constants for the universal counter mode control block
`ifndef UCM_MAP_SVH
`define UCM_MAP_SVH

// ----------------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------------
`define UCM_FN_FREQ      3'h1
`define UCM_FN_PERIOD    3'h2
`define UCM_FN_TI_SINGLE 3'h3
`define UCM_FN_TI_DOUBLE 3'h4
`define UCM_FN_RATIO     3'h5
`define UCM_FN_TOTAL     3'h6

// ----------------------------------------------------------------------
// Range bank layout and timing
// ----------------------------------------------------------------------
`define UCM_RANGE_COUNT  6
`define UCM_CHECK_BIT    6
`define UCM_CLK_HZ       25000000
`define UCM_REF_HZ       1000000
`define UCM_REF_DIV      (`UCM_CLK_HZ / `UCM_REF_HZ)
`define UCM_HOLD_STEP_US 10
`define UCM_HOLD_STEP_CYC ((`UCM_HOLD_STEP_US * `UCM_CLK_HZ) / 1000000)
`define UCM_COUNT_W      32
`define UCM_RESULT_RST   32'h0000_0000

`endif

// File: rtl/ucm_pkg.sv
// Types for the universal counter mode control block
package ucm_pkg;

   typedef enum logic [2:0] {
      UCM_IDLE  = 3'b000,
      UCM_ARM   = 3'b001,
      UCM_COUNT = 3'b011,
      UCM_HOLD  = 3'b010,
      UCM_FROZE = 3'b110
   } ucm_state_e;

   typedef struct packed {
      logic [2:0] fnCode;
      logic [6:0] rangeBank;
      logic       startRise;
      logic       stopRise;
      logic       contactMode;
      logic [3:0] displayTime;
   } ucm_panel_s;

   typedef struct packed {
      logic [31:0] count;
      logic        valid;
      logic        gateOpen;
      logic        selfCheck;
   } ucm_result_s;

endpackage

// File: rtl/ucm_decade_div.sv
// Decade prescaler chain selecting a tap by range index
`timescale 1ns/1ps
module ucm_decade_div
   import ucm_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       inPulse,
   input  wire logic [2:0] rangeIdx,
   output logic            outPulse
);
   // ------------------------------------------------------------------
   // Six cascaded decades; tap 0 passes the input straight through
   // ------------------------------------------------------------------
   logic [3:0] digit_ff     [0:5];
   logic [3:0] nxt_digit    [0:5];
   logic [6:0] carry;
   logic       outPulse_ff;
   logic       nxt_outPulse;

   always_comb begin
      // A pulse on the clearing edge is dropped so a new gate starts empty
      carry[0] = inPulse & ~clear;
      for (int i = 0; i < 6; i++) begin
         nxt_digit[i] = digit_ff[i];
         carry[i+1]   = 1'b0;
         if (clear) begin
            nxt_digit[i] = 4'h0;
         end else if (carry[i]) begin
            if (digit_ff[i] == 4'h9) begin
               nxt_digit[i] = 4'h0;
               carry[i+1]   = 1'b1;
            end else begin
               nxt_digit[i] = digit_ff[i] + 4'h1;
            end
         end
      end
      nxt_outPulse = (rangeIdx < 3'h6) ? carry[rangeIdx] : carry[0];
   end

   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 6; i++) begin
         digit_ff[i] <= rst ? 4'h0 : nxt_digit[i];
      end
      outPulse_ff <= rst ? 1'b0 : nxt_outPulse;
   end

   assign outPulse = outPulse_ff;
endmodule // ucm_decade_div

// File: rtl/ucm_mode_ctrl.sv
// Measurement control for a six-function universal counter
`timescale 1ns/1ps
`include "ucm_map.svh"
// Behaviour
// - Codes 1,2,5: frequency, period, ratio
// - Code 3: start and stop on B
// - Code 4: start on B, stop A
// - Code 6: totalize A prescaled by range
// - Seven buttons: six decade ranges, check
// - Check selects self-check, release returns normal
// - Self-check replaces A with 1 MHz reference
// - Manual start/stop in interval and totalize
// - Independent start and stop edge polarity
// - Polarity also applies in contact mode
// - Reset clears everything, starts new cycle
// - Larger display time gives longer hold
// - Extreme hold freezes result until reset
// - Frequency: gate A pulses, auto restart
// - Period: divided A gates reference count
module ucm_mode_ctrl
   import ucm_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire ucm_panel_s  panel,
   input  wire logic        chanA,
   input  wire logic        chanB,
   input  wire logic        manualStart,
   input  wire logic        manualStop,
   input  wire logic        resetCmd,
   output ucm_result_s      result
);
   // ------------------------------------------------------------------
   // Function decode
   // ------------------------------------------------------------------
   function automatic logic [2:0] fnDecode(input logic [2:0] code);
      if (code >= `UCM_FN_FREQ && code <= `UCM_FN_TOTAL) begin
         fnDecode = code;
      end else begin
         fnDecode = `UCM_FN_FREQ;
      end
   endfunction

   function automatic logic [2:0] rangeDecode(input logic [6:0] bank);
      rangeDecode = 3'h0;
      for (int i = `UCM_RANGE_COUNT - 1; i >= 0; i--) begin
         if (bank[i]) begin
            rangeDecode = i[2:0];
         end
      end
   endfunction

   function automatic logic edgeOf(input logic cur, input logic prev, input logic rise);
      edgeOf = rise ? (cur & ~prev) : (~cur & prev);
   endfunction

   logic [2:0] fn;
   logic [2:0] rangeIdx;
   logic       selfCheck;
   assign fn        = fnDecode(panel.fnCode);
   assign rangeIdx  = rangeDecode(panel.rangeBank);
   assign selfCheck = panel.rangeBank[`UCM_CHECK_BIT];

   // ------------------------------------------------------------------
   // 1 MHz reference from the 25 MHz standard
   // ------------------------------------------------------------------
   logic [4:0] refDiv_ff;
   logic [4:0] nxt_refDiv;
   logic       refTick;
   logic       refLevel;
   always_comb begin
      refTick    = (refDiv_ff == 5'(`UCM_REF_DIV - 1));
      nxt_refDiv = refTick ? 5'h00 : refDiv_ff + 5'h01;
      refLevel   = (refDiv_ff < 5'(`UCM_REF_DIV / 2));
   end

   // ------------------------------------------------------------------
   // Input edges; check substitutes the reference for channel A
   // ------------------------------------------------------------------
   logic srcA;
   logic prevA_ff;
   logic prevB_ff;
   logic aRise;
   logic bStartEdge;
   logic bStopEdge;
   logic aStopEdge;
   logic bRise;
   assign srcA       = selfCheck ? refLevel : chanA;
   assign aRise      = srcA & ~prevA_ff;
   assign bRise      = chanB & ~prevB_ff;
   assign bStartEdge = edgeOf(chanB, prevB_ff, panel.startRise);
   assign bStopEdge  = edgeOf(chanB, prevB_ff, panel.stopRise);
   assign aStopEdge  = edgeOf(srcA, prevA_ff, panel.stopRise);

   // ------------------------------------------------------------------
   // Gate and count sources per function
   // ------------------------------------------------------------------
   logic tbIn;
   logic tbOut;
   logic countPulse;
   logic gateCtl;
   logic startEv;
   logic stopEv;
   logic manualOk;
   always_comb begin
      tbIn       = refTick;
      countPulse = aRise;
      gateCtl    = 1'b0;
      startEv    = 1'b0;
      stopEv     = 1'b0;
      manualOk   = 1'b0;
      unique case (fn)
         `UCM_FN_FREQ: begin
            tbIn       = refTick;
            countPulse = aRise;
            gateCtl    = 1'b1;
         end
         `UCM_FN_PERIOD: begin
            tbIn       = aRise;
            countPulse = refTick;
            gateCtl    = 1'b1;
         end
         `UCM_FN_RATIO: begin
            tbIn       = bRise;
            countPulse = aRise;
            gateCtl    = 1'b1;
         end
         `UCM_FN_TI_SINGLE: begin
            tbIn       = refTick;
            countPulse = tbOut;
            startEv    = bStartEdge;
            stopEv     = bStopEdge;
            manualOk   = 1'b1;
         end
         `UCM_FN_TI_DOUBLE: begin
            tbIn       = refTick;
            countPulse = tbOut;
            startEv    = bStartEdge;
            stopEv     = aStopEdge;
            manualOk   = 1'b1;
         end
         `UCM_FN_TOTAL: begin
            tbIn       = aRise;
            countPulse = tbOut;
            startEv    = bStartEdge;
            stopEv     = bStopEdge;
            manualOk   = 1'b1;
         end
         default: begin
            tbIn = refTick;
         end
      endcase
      if (manualOk) begin
         startEv = startEv | manualStart;
         stopEv  = stopEv | manualStop;
      end
   end

   // ------------------------------------------------------------------
   // Time base decades
   // ------------------------------------------------------------------
   logic tbClear;
   ucm_decade_div u_tb (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clear    (tbClear),
      .inPulse  (tbIn),
      .rangeIdx (rangeIdx),
      .outPulse (tbOut)
   );

   // ------------------------------------------------------------------
   // Measurement sequencer
   // ------------------------------------------------------------------
   ucm_state_e state_ff;
   ucm_state_e nxt_state;
   logic [31:0] count_ff;
   logic [31:0] nxt_count;
   logic [31:0] shown_ff;
   logic [31:0] nxt_shown;
   logic        valid_ff;
   logic        nxt_valid;
   logic [23:0] hold_ff;
   logic [23:0] nxt_hold;
   logic [23:0] holdTarget;
   logic        infinite;
   // Hold grows linearly with the knob; a 4-bit knob is coarse but monotonic
   assign holdTarget = 24'(`UCM_HOLD_STEP_CYC) * {20'h0_0000, panel.displayTime};
   assign infinite   = (panel.displayTime == 4'hF);

   always_comb begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      nxt_shown = shown_ff;
      nxt_valid = valid_ff;
      nxt_hold  = hold_ff;
      tbClear   = 1'b0;
      if (resetCmd) begin
         // Clears the display too, then re-arms at once
         nxt_state = UCM_ARM;
         nxt_count = `UCM_RESULT_RST;
         nxt_shown = `UCM_RESULT_RST;
         nxt_valid = 1'b0;
         nxt_hold  = 24'h00_0000;
         tbClear   = 1'b1;
      end else begin
         unique case (state_ff)
            UCM_IDLE: begin
               nxt_state = UCM_ARM;
            end
            UCM_ARM: begin
               nxt_count = `UCM_RESULT_RST;
               if (gateCtl) begin
                  // Gate opens on a time-base boundary, so it spans whole periods
                  if (tbIn) begin
                     tbClear   = 1'b1;
                     nxt_state = UCM_COUNT;
                  end
               end else if (startEv) begin
                  tbClear   = 1'b1;
                  nxt_state = UCM_COUNT;
               end
            end
            UCM_COUNT: begin
               if (gateCtl ? tbOut : stopEv) begin
                  // A gated close lags the boundary by one cycle; that pulse is the next gate's
                  nxt_shown = count_ff + {31'h0, countPulse & ~gateCtl};
                  nxt_valid = 1'b1;
                  nxt_hold  = 24'h00_0000;
                  nxt_state = infinite ? UCM_FROZE : UCM_HOLD;
               end else if (countPulse) begin
                  nxt_count = count_ff + 32'h0000_0001;
               end
            end
            UCM_HOLD: begin
               nxt_hold = hold_ff + 24'h00_0001;
               if (infinite) begin
                  nxt_state = UCM_FROZE;
               end else if (hold_ff >= holdTarget) begin
                  nxt_state = UCM_ARM;
               end
            end
            UCM_FROZE: begin
               nxt_state = UCM_FROZE;
            end
            default: begin
               nxt_state = UCM_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_ff  <= UCM_IDLE;
         count_ff  <= `UCM_RESULT_RST;
         shown_ff  <= `UCM_RESULT_RST;
         valid_ff  <= 1'b0;
         hold_ff   <= 24'h00_0000;
         refDiv_ff <= 5'h00;
         prevA_ff  <= 1'b0;
         prevB_ff  <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         count_ff  <= nxt_count;
         shown_ff  <= nxt_shown;
         valid_ff  <= nxt_valid;
         hold_ff   <= nxt_hold;
         refDiv_ff <= nxt_refDiv;
         prevA_ff  <= srcA;
         prevB_ff  <= chanB;
      end
   end

   assign result.count     = shown_ff;
   assign result.valid     = valid_ff;
   assign result.gateOpen  = (state_ff == UCM_COUNT);
   assign result.selfCheck = selfCheck;
endmodule // ucm_mode_ctrl

// File: dv/ucm_src.sv
// Square-wave source standing in for the shaped channel inputs
`timescale 1ns/1ps
module ucm_src (
   input  wire logic       ref_clk,
   input  wire logic       load,
   input  wire logic [7:0] halfA,
   input  wire logic [7:0] halfB,
   input  wire logic       initA,
   output logic            chanA = 1'b0,
   output logic            chanB = 1'b0
);
   logic [7:0] cntA = 8'h00;
   logic [7:0] cntB = 8'h00;
   // Falling-edge updates keep levels settled at the sampling edge;
   // a zero half period parks the line at its last level
   always @(negedge ref_clk) begin
      cntA <= (load || cntA + 8'h01 >= halfA) ? 8'h00 : cntA + 8'h01;
      cntB <= (load || cntB + 8'h01 >= halfB) ? 8'h00 : cntB + 8'h01;
      if (load) begin
         chanA <= initA;
         chanB <= 1'b0;
      end else begin
         if (halfA != 8'h00 && cntA + 8'h01 >= halfA) chanA <= ~chanA;
         if (halfB != 8'h00 && cntB + 8'h01 >= halfB) chanB <= ~chanB;
      end
   end
endmodule // ucm_src

// File: dv/ucm_mode_ctrl_sva.sv
// Port checks for the measurement control block
`timescale 1ns/1ps
`include "ucm_map.svh"
module ucm_mode_ctrl_sva
   import ucm_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire ucm_panel_s  panel,
   input wire logic        chanB,
   input wire logic        manualStart,
   input wire logic        manualStop,
   input wire logic        resetCmd,
   input wire ucm_result_s result
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic        gatedFn;
   logic        intvFn;
   logic        freqFn;
   logic [15:0] gapCnt_ff;
   logic        opened_ff;
   assign intvFn  = panel.fnCode inside {3'h3, 3'h4, 3'h6};
   assign freqFn  = !(panel.fnCode inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6});
   assign gatedFn = !intvFn;
   // Gap length, and whether a gate ran since restart (first gate has no hold)
   always_ff @(posedge ref_clk) begin
      gapCnt_ff <= (rst || resetCmd || result.gateOpen) ? 16'h0000 : gapCnt_ff + 16'h0001;
      opened_ff <= (rst || resetCmd) ? 1'b0 : (opened_ff || result.gateOpen);
   end
   reset_clear_a: assert property (
      $fell(rst) |-> result.count == '0 && !result.valid && !result.gateOpen)
      else $error("outputs not cleared by reset");
   cmd_clear_a: assert property (
      resetCmd |=> result.count == '0 && !result.gateOpen) else $error("restart not cleared");
   // Frequency gates wait for the next reference tick, at most 25 cycles away
   gate_rearm_a: assert property (
      resetCmd ##1 (!resetCmd && freqFn) |-> ##[1:25] result.gateOpen)
      else $error("gate not reopened");
   check_flag_a: assert property (
      result.selfCheck == panel.rangeBank[`UCM_CHECK_BIT]) else $error("check flag wrong");
   no_start_a: assert property (
      intvFn && !result.gateOpen && !manualStart && !$past(manualStart) && $stable(chanB)
      && $past(chanB) == $past(chanB, 2) |=> !result.gateOpen) else $error("gate opened");
   manual_stop_a: assert property (
      intvFn && result.gateOpen && manualStop |-> ##[1:2] !result.gateOpen)
      else $error("stop ignored");
   hold_gap_a: assert property (
      $rose(result.gateOpen) && opened_ff && gatedFn && panel.displayTime != 4'hF
      |-> gapCnt_ff >= `UCM_HOLD_STEP_CYC * panel.displayTime
      && (!freqFn || gapCnt_ff <= `UCM_HOLD_STEP_CYC * panel.displayTime + 26))
      else $error("hold length");
   result_hold_a: assert property (
      (!result.gateOpen && !resetCmd)[*4] |-> $stable(result.count))
      else $error("result moved during hold");
   frozen_hold_a: assert property (
      gatedFn && panel.displayTime == 4'hF && $past(result.valid) && !$past(result.gateOpen)
      && !$past(result.gateOpen, 2) && !$past(result.gateOpen, 3) && !resetCmd
      && !$past(resetCmd) && !$past(resetCmd, 2) |-> !result.gateOpen && $stable(result.count))
      else $error("frozen result changed");
   valid_rise_a: assert property (
      $rose(result.valid) |-> $past(result.gateOpen) || $past(result.gateOpen, 2))
      else $error("valid without gate");
endmodule // ucm_mode_ctrl_sva
bind ucm_mode_ctrl ucm_mode_ctrl_sva u_sva (.ref_clk(ref_clk), .rst(rst), .panel(panel),
   .chanB(chanB), .manualStart(manualStart), .manualStop(manualStop), .resetCmd(resetCmd),
   .result(result));

// File: dv/testbench.sv
// Self-checking bench for the measurement control block
`timescale 1ns/1ps
`include "ucm_map.svh"
module testbench;
   import ucm_pkg::*;
   logic        ref_clk;
   logic        rst;
   ucm_panel_s  panel;
   logic        chanA;
   logic        chanB;
   logic        manualStart;
   logic        manualStop;
   logic        resetCmd;
   ucm_result_s result;
   logic        load;
   logic [7:0]  halfA;
   logic [7:0]  halfB;
   logic        initA;
   logic [31:0] held;
   int          n;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cycles = 0;
   ucm_mode_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .panel(panel), .chanA(chanA),
      .chanB(chanB), .manualStart(manualStart), .manualStop(manualStop),
      .resetCmd(resetCmd), .result(result));
   ucm_src u_src (.ref_clk(ref_clk), .load(load), .halfA(halfA), .halfB(halfB),
      .initA(initA), .chanA(chanA), .chanB(chanB));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Cut a hang short well past the expected run length
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles > 60000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      tests_run++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h want=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h want=%h", $time, got, exp);
      end
   endtask
   task automatic wait_gate(input logic lvl, output int cnt);
      cnt = 0;
      while (result.gateOpen !== lvl && cnt < 5000) begin
         @(negedge ref_clk);
         cnt++;
      end
      if (cnt >= 5000) cmp_bit(result.gateOpen, lvl);
   endtask
   task automatic restart();
      resetCmd = 1'b1;
      @(negedge ref_clk);
      resetCmd = 1'b0;
   endtask
   // Manual runs hold the gate for 400 cycles between the two presses
   task automatic measure(input logic [2:0] fn, input logic [6:0] rb, input logic [31:0] exp,
                          input logic [31:0] tol, input logic man);
      int k;
      panel.fnCode = fn;
      panel.rangeBank = rb;
      restart();
      if (man) begin
         manualStart = 1'b1;
         @(negedge ref_clk);
         manualStart = 1'b0;
         repeat (400) @(negedge ref_clk);
         manualStop = 1'b1;
         @(negedge ref_clk);
         manualStop = 1'b0;
      end else begin
         wait_gate(1'b1, k);
      end
      wait_gate(1'b0, k);
      repeat (3) @(negedge ref_clk);
      cmp_range(result.count, exp - tol, exp + tol);
   endtask
   initial begin
      panel = '0;
      panel.displayTime = 4'h1;
      {rst, load} = 2'b11;
      {manualStart, manualStop, resetCmd, initA} = 4'h0;
      {halfA, halfB} = 16'h0000;
      repeat (5) @(negedge ref_clk);
      {rst, load} = 2'b00;
      for (int k = 0; k < 3; k++) measure(3'h1, 7'h40 | (7'h01 << k), 10 ** k, 1, 1'b0);
      cmp_bit(result.selfCheck, 1'b1);
      cmp_bit(result.valid, 1'b1);
      measure(3'h0, 7'h42, 10, 1, 1'b0);
      measure(3'h7, 7'h42, 10, 1, 1'b0);
      measure(3'h2, 7'h42, 10, 1, 1'b0);
      {halfA, halfB} = 16'h1919;
      measure(3'h2, 7'h02, 20, 1, 1'b0);
      cmp_bit(result.selfCheck, 1'b0);
      {halfA, panel.displayTime} = {8'h02, 4'h3};
      measure(3'h5, 7'h02, 125, 2, 1'b0);
      wait_gate(1'b1, n);
      // Hold, then the gate waits for the next B boundary (B period 50 cycles)
      cmp_range(n, 3 * `UCM_HOLD_STEP_CYC + 44, 3 * `UCM_HOLD_STEP_CYC + 48);
      {halfA, halfB, panel.displayTime} = {16'h00FA, 4'h1};
      {panel.startRise, panel.stopRise} = 2'b10;
      measure(3'h3, 7'h01, 10, 1, 1'b0);
      panel.stopRise = 1'b1;
      measure(3'h3, 7'h01, 20, 1, 1'b0);
      {panel.contactMode, panel.startRise} = 2'b10;
      measure(3'h3, 7'h01, 10, 1, 1'b0);
      {panel.contactMode, panel.startRise, halfA, initA, load} = {2'b01, 8'hFA, 2'b11};
      @(negedge ref_clk);
      load = 1'b0;
      measure(3'h4, 7'h01, 10, 1, 1'b0);
      {halfA, halfB} = 16'h0200;
      measure(3'h6, 7'h02, 10, 1, 1'b1);
      panel.displayTime = 4'hF;
      measure(3'h1, 7'h42, 10, 1, 1'b0);
      held = result.count;
      repeat (1500) @(negedge ref_clk);
      cmp_range(result.count, held, held);
      cmp_bit(result.gateOpen, 1'b0);
      restart();
      cmp_range(result.count, 32'h0, 32'h0);
      stop_test();
   end
endmodule // testbench
